// File: core/mbst_pkg.sv
// Package of constants and types for the memory boundary-scan test port
package mbst_pkg;

	// ****************************************
	// Instruction register layout and codes
	// ****************************************
	localparam int IR_WIDTH = 3;                      // Instruction register width
	localparam logic [2:0] INS_EXTEST = 3'h0;         // Drive outputs from boundary cells
	localparam logic [2:0] INS_IDCODE = 3'h1;         // Identification register
	localparam logic [2:0] INS_SAMPLEZ = 3'h2;        // Sample, outputs forced off
	localparam logic [2:0] INS_SAMPLE = 3'h4;         // Sample only
	localparam logic [2:0] IR_RESET_VAL = INS_IDCODE; // Value after reset and capture

	// ****************************************
	// Data register sizes and reset timing
	// ****************************************
	localparam int ID_WIDTH = 32;                   // Identification register width
	localparam int BSR_WIDTH = 16;                  // Default boundary ring length
	localparam int TMS_RESET_EDGES = 5;             // Ones on TMS that force reset
	localparam logic [31:0] ID_VALUE = 32'h0000_0001; // Arbitrary value, bit 0 set

	// ****************************************
	// Controller states
	// ****************************************
	typedef enum logic [3:0] {
		ST_RESET = 4'h0,
		ST_IDLE = 4'h1,
		ST_SEL_DR = 4'h2,
		ST_CAP_DR = 4'h3,
		ST_SHIFT_DR = 4'h4,
		ST_EXIT1_DR = 4'h5,
		ST_PAUSE_DR = 4'h6,
		ST_EXIT2_DR = 4'h7,
		ST_UPD_DR = 4'h8,
		ST_SEL_IR = 4'h9,
		ST_CAP_IR = 4'hA,
		ST_SHIFT_IR = 4'hB,
		ST_EXIT1_IR = 4'hC,
		ST_PAUSE_IR = 4'hD,
		ST_EXIT2_IR = 4'hE,
		ST_UPD_IR = 4'hF
	} mbst_state_t;

endpackage : mbst_pkg

// File: core/mbst_sync.sv
// Two-stage synchroniser for the test pins
`timescale 1ns/10ps
module mbst_sync #(
	parameter int WIDTH = 3
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);

	// First stage, read only by the second stage
	logic [WIDTH-1:0] meta_ff;

	// ****************************************
	// Two flip-flops per bit
	// ****************************************
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			meta_ff <= '0;
			syncOut <= '0;
		end else begin
			meta_ff <= asyncIn;
			syncOut <= meta_ff;
		end
	end

endmodule : mbst_sync

// File: core/mbst_tap.sv
// Boundary-scan test access port of the memory device
`timescale 1ns/10ps
module mbst_tap
	import mbst_pkg::*;
#(
	parameter int BSR_LEN = mbst_pkg::BSR_WIDTH
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic [BSR_LEN-1:0] ringIn,
	output logic tdo,
	output logic tdoEn,
	output logic [BSR_LEN-1:0] ringOut,
	output logic extestDrive,
	output logic dataDrvOff,
	output logic odtDisable,
	output logic [3:0] tapState
);
	import mbst_pkg::*;

	// ****************************************
	// Parameter check
	// ****************************************
	if (BSR_LEN < 2) begin : g_bad_len
		$error("Boundary ring needs at least two cells");
	end

	// ****************************************
	// Pin synchronisation and edge finding
	// ****************************************
	logic [2:0] pinSync;   // Synchronised tck, tms, tdi
	logic tckPrev_ff;      // Last tck level seen
	logic tckRise;         // Rising edge enable
	logic tckFall;         // Falling edge enable
	logic tmsS;
	logic tdiS;
	logic [BSR_LEN-1:0] ringS; // Synchronised ring levels

	// Ring levels are memory pins, so they pass two flops like the test pins
	mbst_sync #(.WIDTH(BSR_LEN)) u_ring_sync (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.asyncIn(ringIn),
		.syncOut(ringS)
	);

	mbst_sync #(.WIDTH(3)) u_sync (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.asyncIn({tck, tms, tdi}),
		.syncOut(pinSync)
	);

	assign tmsS = pinSync[1];
	assign tdiS = pinSync[0];
	// Tms and tdi share tck's delay, so the sample sees setup-valid levels
	assign tckRise = pinSync[2] & ~tckPrev_ff;
	assign tckFall = ~pinSync[2] & tckPrev_ff;

	// Remember the test clock level
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			tckPrev_ff <= 1'b0;
		end else begin
			tckPrev_ff <= pinSync[2];
		end
	end

	// ****************************************
	// Controller state machine
	// ****************************************
	mbst_state_t state_ff;
	mbst_state_t nxt_state;

	// Standard sixteen-state walk; five ones reach reset from anywhere
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_RESET: nxt_state = tmsS ? ST_RESET : ST_IDLE;
			ST_IDLE: nxt_state = tmsS ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: nxt_state = tmsS ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: nxt_state = tmsS ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_SHIFT_DR: nxt_state = tmsS ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_EXIT1_DR: nxt_state = tmsS ? ST_UPD_DR : ST_PAUSE_DR;
			ST_PAUSE_DR: nxt_state = tmsS ? ST_EXIT2_DR : ST_PAUSE_DR;
			ST_EXIT2_DR: nxt_state = tmsS ? ST_UPD_DR : ST_SHIFT_DR;
			ST_UPD_DR: nxt_state = tmsS ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR: nxt_state = tmsS ? ST_RESET : ST_CAP_IR;
			ST_CAP_IR: nxt_state = tmsS ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_SHIFT_IR: nxt_state = tmsS ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_EXIT1_IR: nxt_state = tmsS ? ST_UPD_IR : ST_PAUSE_IR;
			ST_PAUSE_IR: nxt_state = tmsS ? ST_EXIT2_IR : ST_PAUSE_IR;
			ST_EXIT2_IR: nxt_state = tmsS ? ST_UPD_IR : ST_SHIFT_IR;
			ST_UPD_IR: nxt_state = tmsS ? ST_SEL_DR : ST_IDLE;
			default: nxt_state = ST_RESET;
		endcase
	end

	// Moves only on a test clock rising edge
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_ff <= ST_RESET;
		end else if (tckRise) begin
			state_ff <= nxt_state;
		end
	end

	// ****************************************
	// Instruction register
	// ****************************************
	logic [IR_WIDTH-1:0] irShift_ff; // Shift stage
	logic [IR_WIDTH-1:0] irActive_ff; // Instruction in force

	// Capture and shift stage
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			irShift_ff <= IR_RESET_VAL;
		end else if (tckRise) begin
			case (state_ff)
				ST_RESET, ST_CAP_IR: irShift_ff <= IR_RESET_VAL;
				ST_SHIFT_IR: irShift_ff <= {tdiS, irShift_ff[IR_WIDTH-1:1]};
				default: irShift_ff <= irShift_ff;
			endcase
		end
	end

	// New code only takes effect at update
	// Identify is forced on the very rise that enters reset, so the
	// disruptive controls drop without waiting for one more test clock
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			irActive_ff <= IR_RESET_VAL;
		end else if (tckRise) begin
			if (nxt_state == ST_RESET) begin
				irActive_ff <= IR_RESET_VAL;
			end else if (state_ff == ST_UPD_IR) begin
				irActive_ff <= irShift_ff;
			end
		end
	end

	// ****************************************
	// Data registers
	// ****************************************
	logic [ID_WIDTH-1:0] idReg_ff;  // Identification shift stage
	logic [BSR_LEN-1:0] bsr_ff;     // Boundary shift stage
	logic bypass_ff;                // One-bit path for private codes
	logic selBsr;                   // Boundary ring is selected
	logic selId;                    // Identification is selected

	assign selBsr = (irActive_ff == INS_EXTEST) || (irActive_ff == INS_SAMPLEZ)
		|| (irActive_ff == INS_SAMPLE);
	assign selId = (irActive_ff == INS_IDCODE);

	// Capture on Capture-DR, shift on Shift-DR; the register is picked by the code
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			idReg_ff <= ID_VALUE;
			bsr_ff <= '0;
			bypass_ff <= 1'b0;
		end else if (tckRise) begin
			if (state_ff == ST_CAP_DR) begin
				idReg_ff <= ID_VALUE;
				if (selBsr) begin
					bsr_ff <= ringS;
				end
				bypass_ff <= 1'b0;
			end else if (state_ff == ST_SHIFT_DR) begin
				if (selId) begin
					idReg_ff <= {tdiS, idReg_ff[ID_WIDTH-1:1]};
				end else if (selBsr) begin
					bsr_ff <= {tdiS, bsr_ff[BSR_LEN-1:1]};
				end else begin
					bypass_ff <= tdiS;
				end
			end
		end
	end

	// Output latch of boundary cells, changes only at Update-DR
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ringOut <= '0;
		end else if (tckRise && state_ff == ST_UPD_DR && selBsr) begin
			ringOut <= bsr_ff;
		end
	end

	// ****************************************
	// Memory-side controls
	// ****************************************
	// Only the two disruptive codes touch normal operation
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			extestDrive <= 1'b0;
			dataDrvOff <= 1'b0;
			odtDisable <= 1'b0;
		end else begin
			extestDrive <= (irActive_ff == INS_EXTEST);
			dataDrvOff <= (irActive_ff == INS_SAMPLEZ);
			odtDisable <= (irActive_ff == INS_EXTEST) || (irActive_ff == INS_SAMPLEZ);
		end
	end

	// ****************************************
	// Serial output, falling edge
	// ****************************************
	// Launch on the falling test clock so the tester samples on the next rise
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			tdo <= 1'b0;
			tdoEn <= 1'b0;
		end else if (tckFall) begin
			tdoEn <= (state_ff == ST_SHIFT_IR) || (state_ff == ST_SHIFT_DR);
			if (state_ff == ST_SHIFT_IR) begin
				tdo <= irShift_ff[0];
			end else if (selId) begin
				tdo <= idReg_ff[0];
			end else if (selBsr) begin
				tdo <= bsr_ff[0];
			end else begin
				tdo <= bypass_ff;
			end
		end
	end

	// State for observation
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			tapState <= 4'h0;
		end else begin
			tapState <= state_ff;
		end
	end

endmodule : mbst_tap

// File: tb/mbst_jtag_model.sv
// Model of the external test controller
`timescale 1ns/10ps
module mbst_jtag_model (
	input wire logic sys_clk,
	input wire logic tdo,
	input wire logic tdoEn,
	output logic tck,
	output logic tms,
	output logic tdi
);
	// Clock parked low, pulled-up lines high until the first pulse
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end
	// One test clock: low 5 cycles, high 3; undriven output reads unknown
	task automatic pulse(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		repeat (5) @(posedge sys_clk);
		#1 tck = 1'b1;
		q = tdoEn ? tdo : 1'bx;
		repeat (3) @(posedge sys_clk);
		#1 tck = 1'b0;
	endtask : pulse
endmodule : mbst_jtag_model

// File: tb/mbst_tap_sva.sv
// Checker of the test port pin behaviour
`timescale 1ns/10ps
module mbst_tap_sva
	import mbst_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdo,
	input wire logic tdoEn,
	input wire logic extestDrive,
	input wire logic dataDrvOff,
	input wire logic odtDisable,
	input wire logic [3:0] tapState
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	logic tckQ_ff; // Pin level one cycle back
	logic [2:0] onesCnt_ff; // Rises with mode select high, saturates at five
	// Count ones seen at pin rises; a zero restarts the run
	always_ff @(posedge sys_clk) begin
		tckQ_ff <= tck;
		if (sys_rst) begin
			onesCnt_ff <= 3'h0;
		end else if (tck && !tckQ_ff) begin
			onesCnt_ff <= !tms ? 3'h0 : (onesCnt_ff == 3'h5 ? 3'h5 : onesCnt_ff + 3'h1);
		end
	end
	chk_rst_quiet: assert property ($fell(sys_rst) |-> tapState == ST_RESET && !tdoEn)
		else $error("port not idle after reset");
	chk_state_held: assert property ((!tck)[*6] |-> $stable(tapState))
		else $error("state moved without test clock");
	chk_dout_fall: assert property ($changed(tdo) || $changed(tdoEn) |-> !$past(tck, 2))
		else $error("serial out moved outside low phase");
	chk_en_shift: assert property ($rose(tdoEn) |-> tapState == ST_SHIFT_IR || tapState == ST_SHIFT_DR)
		else $error("output enabled outside shift");
	chk_en_off: assert property ((!tck && tapState != ST_SHIFT_IR && tapState != ST_SHIFT_DR)[*6]
		|-> !tdoEn)
		else $error("output still enabled");
	chk_five_ones: assert property ($rose(onesCnt_ff == 3'h5) |-> ##[1:6] tapState == ST_RESET)
		else $error("five ones did not reset");
	chk_hiz_pair: assert property (dataDrvOff |-> odtDisable && !extestDrive)
		else $error("high impedance mode incomplete");
	chk_extest_odt: assert property (extestDrive |-> odtDisable)
		else $error("termination left on in extest");
	chk_ctrl_update: assert property ($changed({extestDrive, dataDrvOff, odtDisable}) |->
		$past(tapState) == ST_UPD_IR || $past(tapState, 2) == ST_UPD_IR || tapState == ST_RESET)
		else $error("controls changed off update");
endmodule : mbst_tap_sva

// File: tb/testbench.sv
// Self-checking bench for the memory test port
`timescale 1ns/10ps
module testbench;
	import mbst_pkg::*;
	logic sysClk = 1'b0;
	logic sysRst = 1'b1;
	logic tck, tms, tdi, tdo, tdoEn, extestDrive, dataDrvOff, odtDisable;
	logic [BSR_WIDTH-1:0] ringIn = 16'hA5C3; // Fixed ring levels
	logic [BSR_WIDTH-1:0] ringOut;
	logic [3:0] tapState;
	int err_count = 0;
	int check_count = 0;
	always #20 sysClk = ~sysClk;
	mbst_tap DUT (.sys_clk(sysClk), .sys_rst(sysRst), .tck(tck), .tms(tms), .tdi(tdi),
		.ringIn(ringIn), .tdo(tdo), .tdoEn(tdoEn), .ringOut(ringOut),
		.extestDrive(extestDrive), .dataDrvOff(dataDrvOff), .odtDisable(odtDisable),
		.tapState(tapState));
	mbst_jtag_model ctl (.sys_clk(sysClk), .tdo(tdo), .tdoEn(tdoEn), .tck(tck), .tms(tms),
		.tdi(tdi));
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	// Idle to Idle through one instruction or data scan
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
		output logic [31:0] dout);
		logic q;
		dout = '0;
		ctl.pulse(1'b1, 1'b1, q);
		if (ir) ctl.pulse(1'b1, 1'b1, q);
		ctl.pulse(1'b0, 1'b1, q);
		ctl.pulse(1'b0, 1'b1, q);
		for (int k = 0; k < n; k++) begin
			ctl.pulse(k == n - 1, din[k], q);
			dout[k] = q;
		end
		ctl.pulse(1'b1, 1'b1, q);
		ctl.pulse(1'b0, 1'b1, q);
		repeat (4) @(posedge sysClk); // Let outputs settle
		#1;
	endtask : scan
	task automatic report_and_stop();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : report_and_stop
	// Watchdog: the run needs well under 100 us
	initial begin
		#200000;
		err_count++;
		report_and_stop();
	end
	// Main sequence
	initial begin
		static logic [2:0] codes [4] = '{INS_SAMPLEZ, INS_EXTEST, INS_SAMPLE, INS_IDCODE};
		static logic [2:0] ctrl [4] = '{3'h3, 3'h5, 3'h0, 3'h0}; // Extest, drivers off, odt off
		logic [31:0] d;
		logic q;
		repeat (5) @(posedge sysClk);
		#1 sysRst = 1'b0;
		repeat (4) @(posedge sysClk);
		#1;
		check("state after reset", ST_RESET, tapState);
		ctl.pulse(1'b0, 1'b1, q);
		for (int i = 0; i < 4; i++) begin
			scan(1'b1, 3, codes[i], d);
			check("ir capture", 32'h0000_0001, d);
			check("controls", ctrl[i], {extestDrive, dataDrvOff, odtDisable});
			check("tdo enable idle", 1'b0, tdoEn);
		end
		scan(1'b0, ID_WIDTH, 32'h0000_0000, d);
		check("id register", ID_VALUE, d);
		scan(1'b1, 3, INS_EXTEST, d);
		scan(1'b0, BSR_WIDTH, 32'h0000_3C5A, d);
		check("ring capture", ringIn, d);
		check("ring out", 32'h0000_3C5A, ringOut);
		ctl.pulse(1'b1, 1'b1, q);
		ctl.pulse(1'b0, 1'b1, q);
		ctl.pulse(1'b0, 1'b1, q);
		for (int i = 0; i < 5; i++) ctl.pulse(1'b1, 1'b1, q);
		repeat (4) @(posedge sysClk);
		#1;
		check("state after ones", ST_RESET, tapState);
		check("controls after ones", 3'h0, {extestDrive, dataDrvOff, odtDisable});
		report_and_stop();
	end
endmodule : testbench
bind mbst_tap mbst_tap_sva chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .tck(tck), .tms(tms),
	.tdo(tdo), .tdoEn(tdoEn), .extestDrive(extestDrive), .dataDrvOff(dataDrvOff),
	.odtDisable(odtDisable), .tapState(tapState));
